/* File: src/tsb_pkg.sv */
// package for the tri-state slave bus port: shared constants and types
// assumes both ends run on one 50 MHz clock, sys_clk, with srst
package tsb_pkg;
   localparam int TSB_ADDR_W_DEF  = 8;
   localparam int TSB_DATA_W_DEF  = 32;
   localparam int TSB_ADDR_W_MAX  = 32;
   localparam int TSB_ADDR_W_MIN  = 1;
   localparam int TSB_BYTE_W      = 8;
   localparam int TSB_WORDS_DEF   = 16;
   localparam int TSB_RD_CYCLES   = 2;
   localparam int TSB_WR_CYCLES   = 1;
   typedef enum logic [1:0] {
      TSB_IDLE,
      TSB_WRITE,
      TSB_READ,
      TSB_DONE
   } tsb_state_t;
endpackage

/* File: src/tsb_if.sv */
// interface joining the bus controller and the tri-state slave
// the shared data wire is resolved by the testbench from the two enables
interface tsb_if #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 32
) ();
   logic [ADDR_W-1:0]   address;
   logic                read;
   logic                write;
   logic                chip_select;
   logic                output_enable;
   logic [DATA_W/8-1:0] byte_enable;
   logic                transfer_start_marker;
   logic [DATA_W-1:0]   ctl_data_out;
   logic                ctl_data_oe;
   logic [DATA_W-1:0]   slv_data_out;
   logic                slv_data_oe;
   logic [DATA_W-1:0]   data_in;
   modport controller (
      output address, read, write, chip_select, output_enable,
      output byte_enable, transfer_start_marker, ctl_data_out, ctl_data_oe,
      input  data_in
   );
   modport slave (
      input  address, read, write, chip_select, output_enable,
      input  byte_enable, transfer_start_marker, data_in,
      output slv_data_out, slv_data_oe
   );
endinterface

/* File: src/tsb_slave.sv */
// tri-state bus slave end: a small byte-addressed word memory
// assumes the controller follows the bus timing; data_in is the wire level
module tsb_slave
   import tsb_pkg::*;
#(
   parameter int ADDR_W = TSB_ADDR_W_DEF,
   parameter int DATA_W = TSB_DATA_W_DEF,
   parameter int WORDS  = TSB_WORDS_DEF
) (
   input  wire logic sys_clk,
   input  wire logic srst,
   tsb_if.slave      bus,
   output logic      write_seen,
   output logic      read_seen,
   output logic [ADDR_W-1:0] last_address
);
   localparam int LANES = DATA_W / TSB_BYTE_W;
   localparam int LSB   = $clog2(LANES);
   localparam int IDX_W = (WORDS > 1) ? $clog2(WORDS) : 1;

   initial begin
      if (ADDR_W < TSB_ADDR_W_MIN || ADDR_W > TSB_ADDR_W_MAX)
         $error("tsb_slave: address width out of range");
      if (!(DATA_W inside {8, 16, 32, 64, 128, 256, 512, 1024}))
         $error("tsb_slave: illegal data width");
      if (ADDR_W <= LSB)
         $error("tsb_slave: address too narrow for data width");
   end

   logic [DATA_W-1:0] mem [WORDS];
   logic [DATA_W-1:0] data_out;
   logic              data_oe;
   logic              next_write_seen;
   logic              next_read_seen;
   logic [ADDR_W-1:0] next_last_address;
   logic [DATA_W-1:0] next_data_out;
   logic              next_data_oe;
   logic [IDX_W-1:0]  idx;
   logic              sel_wr;
   logic              sel_rd;

   // byte offset -> word index; low lane bits are implied by byte_enable
   assign idx    = IDX_W'(bus.address >> LSB);
   assign sel_wr = bus.chip_select && bus.write;
   assign sel_rd = bus.chip_select && bus.read;

   always_comb begin
      next_write_seen   = sel_wr && bus.transfer_start_marker;
      next_read_seen    = sel_rd && bus.transfer_start_marker;
      next_last_address = last_address;
      if (sel_wr || sel_rd)
         next_last_address = bus.address;
      // full word regardless of lanes: reads have no side effects
      next_data_out = mem[idx];
      // registered enable: one cycle after select+read+oe, off one after
      next_data_oe = sel_rd && bus.output_enable;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         write_seen   <= 1'b0;
         read_seen    <= 1'b0;
         last_address <= '0;
         data_out     <= '0;
         data_oe      <= 1'b0;
      end else begin
         write_seen   <= next_write_seen;
         read_seen    <= next_read_seen;
         last_address <= next_last_address;
         data_out     <= next_data_out;
         data_oe      <= next_data_oe;
      end
   end

   // memory has no reset; contents are undefined until written
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < LANES; i++) begin
         if (!srst && sel_wr && bus.byte_enable[i])
            mem[idx][i*TSB_BYTE_W +: TSB_BYTE_W] <=
               bus.data_in[i*TSB_BYTE_W +: TSB_BYTE_W];
      end
   end

   // the live enable also gates the driver so oe drop releases at once
   assign bus.slv_data_out = data_out;
   assign bus.slv_data_oe  = data_oe && bus.output_enable
                             && bus.chip_select;
endmodule

/* File: src/tsb_controller.sv */
// on-chip controller end of the tri-state bus
// assumes a user requests one transfer at a time and waits for done
module tsb_controller
   import tsb_pkg::*;
#(
   parameter int ADDR_W = TSB_ADDR_W_DEF,
   parameter int DATA_W = TSB_DATA_W_DEF
) (
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   input  wire logic                  req,
   input  wire logic                  req_write,
   input  wire logic [ADDR_W-1:0]     req_address,
   input  wire logic [DATA_W/8-1:0]   req_byte_enable,
   input  wire logic [DATA_W-1:0]     req_wdata,
   output logic                       busy,
   output logic                       done,
   output logic [DATA_W-1:0]          rdata,
   tsb_if.controller                  bus
);
   localparam int LANES = DATA_W / TSB_BYTE_W;

   initial begin
      if (!(DATA_W inside {8, 16, 32, 64, 128, 256, 512, 1024}))
         $error("tsb_controller: illegal data width");
   end

   // legal lane pattern: aligned, power-of-two run of lanes
   function automatic logic lanes_ok(input logic [LANES-1:0] be);
      logic ok;
      ok = 1'b0;
      for (int s = 1; s <= LANES; s = s * 2)
         for (int o = 0; o < LANES; o = o + s)
            if (be == LANES'(((64'd1 << s) - 64'd1) << o))
               ok = 1'b1;
      return ok;
   endfunction

   tsb_state_t         state, next_state;
   logic [1:0]         cnt, next_cnt;
   logic [ADDR_W-1:0]  addr, next_addr;
   logic [LANES-1:0]   be, next_be;
   logic [DATA_W-1:0]  wdata, next_wdata;
   logic [DATA_W-1:0]  next_rdata;
   logic               start, next_start;
   logic               next_done;

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_addr  = addr;
      next_be    = be;
      next_wdata = wdata;
      next_rdata = rdata;
      next_start = 1'b0;
      next_done  = 1'b0;
      unique case (state)
         TSB_IDLE: begin
            if (req && lanes_ok(req_byte_enable)) begin
               next_addr  = req_address;
               next_be    = req_byte_enable;
               next_wdata = req_wdata;
               next_start = 1'b1;
               next_cnt   = 2'(req_write ? TSB_WR_CYCLES : TSB_RD_CYCLES);
               next_state = req_write ? TSB_WRITE : TSB_READ;
            end
         end
         TSB_WRITE, TSB_READ: begin
            if (cnt == 2'd1) begin
               if (state == TSB_READ)
                  next_rdata = bus.data_in;
               next_done  = 1'b1;
               next_state = TSB_DONE;
            end else
               next_cnt = cnt - 2'd1;
         end
         TSB_DONE: next_state = TSB_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state <= TSB_IDLE;
         cnt   <= '0;
         addr  <= '0;
         be    <= '0;
         wdata <= '0;
         rdata <= '0;
         start <= 1'b0;
         done  <= 1'b0;
         busy  <= 1'b0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         addr  <= next_addr;
         be    <= next_be;
         wdata <= next_wdata;
         rdata <= next_rdata;
         start <= next_start;
         done  <= next_done;
         busy  <= (next_state != TSB_IDLE);
      end
   end

   // all strobes active high; select never without read or write
   assign bus.address               = addr;
   assign bus.write                 = (state == TSB_WRITE);
   assign bus.read                  = (state == TSB_READ);
   assign bus.chip_select           = bus.write || bus.read;
   assign bus.output_enable         = (state == TSB_READ);
   assign bus.byte_enable           = be;
   assign bus.transfer_start_marker = start;
   assign bus.ctl_data_out          = wdata;
   assign bus.ctl_data_oe           = (state == TSB_WRITE);
endmodule

/* File: tb/tsb_properties.sv */
// checker: bus timing seen between the controller and slave ends
// assumes the tsb_if signals are handed in as plain inputs
module tsb_properties #(
   parameter int DATA_W = 32
) (
   input wire logic                sys_clk,
   input wire logic                srst,
   input wire logic                read,
   input wire logic                write,
   input wire logic                chip_select,
   input wire logic                output_enable,
   input wire logic [DATA_W/8-1:0] byte_enable,
   input wire logic                transfer_start_marker,
   input wire logic                ctl_data_oe,
   input wire logic                slv_data_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   a_oe_release: assert property (
      !output_enable |-> !slv_data_oe)
      else $error("slave drives with output enable low");
   a_read_drive: assert property (
      slv_data_oe |-> chip_select && read)
      else $error("slave drives outside a selected read");
   a_no_clash: assert property (!(slv_data_oe && ctl_data_oe))
      else $error("both ends drive the data wire");
   a_read_turn: assert property ($rose(read) |->
      !slv_data_oe ##1 slv_data_oe && read ##1 !slv_data_oe && !read)
      else $error("read data window misplaced");
   a_start_pulse: assert property (transfer_start_marker |=>
      !transfer_start_marker)
      else $error("start marker longer than one cycle");
   a_start_strobe: assert property ($rose(chip_select) |->
      transfer_start_marker && (read || write))
      else $error("transfer began without start marker");
   a_write_data: assert property (
      write && chip_select |-> ctl_data_oe)
      else $error("controller not driving during write");
   a_select_pair: assert property (chip_select |-> read ^ write)
      else $error("select without exactly one strobe");
   a_lane_shape: assert property (write |->
      $countones(byte_enable) inside {1, 2, 4})
      else $error("write with odd lane count");
endmodule

/* File: tb/tb_tristate_slave_bus_port.sv */
// self-checking bench: controller and slave joined by one tsb_if
// assumes the src/ files are compiled first; idle wire toggles, not holds
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
   $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb_tristate_slave_bus_port import tsb_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 0, srst = 1, req = 0, req_write = 0, busy, done;
   logic        wr_seen, rd_seen;
   logic [7:0]  req_address = '0, last_address;
   logic [3:0]  req_byte_enable = '0;
   logic [31:0] req_wdata = '0, rdata, hold = '0, q;
   int          bad_count = 0, compares = 0, n;
   tsb_if #(.ADDR_W(8), .DATA_W(32)) bus_if ();
   always #10 sys_clk = ~sys_clk;
   assign bus_if.data_in = bus_if.ctl_data_oe ? bus_if.ctl_data_out :
      bus_if.slv_data_oe ? bus_if.slv_data_out : ~hold;
   always @(posedge sys_clk) hold <= bus_if.data_in;
   tsb_controller i_tsb_controller (.sys_clk, .srst, .req, .req_write,
      .req_address, .req_byte_enable, .req_wdata, .busy, .done, .rdata,
      .bus(bus_if));
   tsb_slave i_tsb_slave (.sys_clk, .srst, .bus(bus_if),
      .write_seen(wr_seen), .read_seen(rd_seen), .last_address);
   tsb_properties #(.DATA_W(32)) i_tsb_properties (.sys_clk, .srst,
      .read(bus_if.read), .write(bus_if.write),
      .chip_select(bus_if.chip_select), .ctl_data_oe(bus_if.ctl_data_oe),
      .output_enable(bus_if.output_enable), .slv_data_oe(bus_if.slv_data_oe),
      .byte_enable(bus_if.byte_enable),
      .transfer_start_marker(bus_if.transfer_start_marker));
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic send(input logic w, input logic [7:0] a,
         input logic [3:0] be, input logic [31:0] d);
      @(posedge sys_clk);
      req <= 1'b1;
      req_write <= w;
      req_address <= a;
      req_byte_enable <= be;
      req_wdata <= d;
      @(posedge sys_clk);
      req <= 1'b0;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [3:0] be, input logic [31:0] d);
      send(w, a, be, d);
      n = 0;
      while (done !== 1'b1) begin
         @(posedge sys_clk);
         n++;
         // the start-marked cycle is seen one edge after it was taken
         if (n == 2)
            `CHK(w ? wr_seen : rd_seen, 1'b1)
         if (n > 20) begin
            bad_count++;
            complete_run();
         end
      end
      q = rdata;
      `CHK(n, w ? TSB_WR_CYCLES + 1 : TSB_RD_CYCLES + 1)
      `CHK(last_address, a)
   endtask
   task automatic t_lanes();
      logic [3:0] pats [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC};
      logic [31:0] exp = 32'h1234_5678;
      xfer(1'b1, 8'h04, 4'hF, exp);
      foreach (pats[i]) begin
         xfer(1'b1, 8'h04, pats[i], {4{8'(8'hA0 + i)}});
         for (int b = 0; b < 4; b++)
            if (pats[i][b]) exp[8*b +: 8] = 8'(8'hA0 + i);
         xfer(1'b0, 8'h04, 4'hF, 32'h0000_0000);
         `CHK(q, exp)
      end
      $display("lanes test done");
   endtask
   task automatic t_read();
      // byte offset inside the word and above the depth both land on word 2
      xfer(1'b1, 8'h08, 4'hF, 32'hCAFE_F00D);
      xfer(1'b0, 8'h4B, 4'h2, 32'h0000_0000);
      `CHK(q, 32'hCAFE_F00D)
      $display("read test done");
   endtask
   task automatic t_refused();
      send(1'b1, 8'h08, 4'h6, 32'h0000_0000);
      repeat (6) begin
         @(posedge sys_clk);
         `CHK(done, 1'b0)
         `CHK(busy, 1'b0)
      end
      xfer(1'b0, 8'h08, 4'hF, 32'h0000_0000);
      `CHK(q, 32'hCAFE_F00D)
      $display("refused test done");
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      t_lanes();
      t_read();
      t_refused();
      complete_run();
   end
endmodule
